// >>> gate_side_model.sv
`timescale 1ns/1ps
module gate_side_model (
  input  wire logic mclk,
  input  wire logic gate_req,
  input  wire logic cap_req,
  output logic      gate_pin,
  output logic      comparator_one_output,
  output logic      comparator_two_output,
  output logic      capture_event,
  output logic      external_count_pin
);
  logic [2:0] div_reg = 3'h0;

  // external count clock runs free: one rising edge every 8 cycles
  always_ff @(posedge mclk)
  begin
    gate_pin <= gate_req;
    comparator_one_output <= gate_req;
    comparator_two_output <= !gate_req;
    capture_event <= cap_req;
    div_reg <= div_reg + 3'h1;
    external_count_pin <= div_reg[2];
  end
endmodule : gate_side_model

// >>> gated_sixteen_bit_timer.sv
`timescale 1ns/1ps
module gated_sixteen_bit_timer
  import gtimer_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_pin,
  input  wire logic        secondary_osc_input,
  output logic             secondary_osc_output,
  input  wire logic        gate_pin,
  input  wire logic        timer0_overflow,
  input  wire logic        comparator_one_output,
  input  wire logic        comparator_two_output,
  input  wire logic        capture_event,
  input  wire logic        sleep_mode,
  output logic             compare_event,
  output logic             irq,
  output logic             wake
);
  import gtimer_pkg::*;

  logic [7:0]  tctl_reg;
  logic [7:0]  gctl_reg;
  logic [15:0] count_reg;
  logic [15:0] ccpv_reg;
  logic [1:0]  ccp_mode_reg;
  logic [2:0]  flags_reg;
  logic [4:0]  ien_reg;
  logic [1:0]  div4_reg;
  logic [2:0]  ps_reg;
  logic [2:0]  ext_sync_reg;
  logic [2:0]  osc_sync_reg;
  logic [2:0]  gpin_sync_reg;
  logic [2:0]  c1_sync_reg;
  logic [2:0]  c2_sync_reg;
  logic        ext_lvl_reg;
  logic        osc_lvl_reg;
  logic        gpin_lvl_reg;
  logic        c1_lvl_reg;
  logic        c2_lvl_reg;
  logic        src_prev_reg;
  logic        gsel_prev_reg;
  logic        toggle_reg;
  logic        gval_prev_reg;
  logic        pulse_open_reg;
  logic        cmp_prev_reg;

  logic       wr;
  logic       timer_on;
  logic [1:0] cs;
  logic [1:0] ps;
  logic       tick;
  logic       src_level;
  logic       gsel;
  logic       gate_in;
  logic       gval;
  logic       gate_ok;
  logic       ps_done;
  logic       inc;
  logic       roll;
  logic       count_wr;
  logic       trig_clear;
  logic       match;
  logic       osc_run;

  assign wr       = psel && penable && pwrite;
  assign timer_on = tctl_reg[TC_ON];
  assign cs       = tctl_reg[TC_CS_LO +: 2];
  assign ps       = tctl_reg[TC_PS_LO +: 2];
  assign pready   = 1'b1;
  assign pslverr  = 1'b0;

  assign osc_run = tctl_reg[TC_OSC_EN];
  assign secondary_osc_output = osc_run && !secondary_osc_input;

  // three-stage synchronisers; level changes once stages two and three agree
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_sync_reg  <= 3'h0;
      osc_sync_reg  <= 3'h0;
      gpin_sync_reg <= 3'h0;
      c1_sync_reg   <= 3'h0;
      c2_sync_reg   <= 3'h0;
      ext_lvl_reg   <= 1'b0;
      osc_lvl_reg   <= 1'b0;
      gpin_lvl_reg  <= 1'b0;
      c1_lvl_reg    <= 1'b0;
      c2_lvl_reg    <= 1'b0;
    end
    else
    begin
      ext_sync_reg  <= {ext_sync_reg[1:0], external_count_pin};
      osc_sync_reg  <= {osc_sync_reg[1:0], secondary_osc_input};
      gpin_sync_reg <= {gpin_sync_reg[1:0], gate_pin};
      c1_sync_reg   <= {c1_sync_reg[1:0], comparator_one_output};
      c2_sync_reg   <= {c2_sync_reg[1:0], comparator_two_output};
      if (ext_sync_reg[1] == ext_sync_reg[2])
        ext_lvl_reg <= ext_sync_reg[2];
      if (osc_sync_reg[1] == osc_sync_reg[2])
        osc_lvl_reg <= osc_sync_reg[2];
      if (gpin_sync_reg[1] == gpin_sync_reg[2])
        gpin_lvl_reg <= gpin_sync_reg[2];
      if (c1_sync_reg[1] == c1_sync_reg[2])
        c1_lvl_reg <= c1_sync_reg[2];
      if (c2_sync_reg[1] == c2_sync_reg[2])
        c2_lvl_reg <= c2_sync_reg[2];
    end
  end

  // fosc/4 is every fourth mclk edge
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      div4_reg <= 2'h0;
    else
      div4_reg <= div4_reg + 2'h1;
  end

  // the sync bypass bit only lets the external source count in sleep; the pin is always
  // sampled, which costs a few cycles of latency but keeps one clock
  // clock source mux
  always_comb
  begin
    src_level = 1'b0;
    tick      = 1'b0;
    case (cs)
      CS_FOSC4: tick = (div4_reg == FOSC4_DIV_LAST);
      CS_FOSC:  tick = 1'b1;
      CS_EXT:
      begin
        src_level = osc_run ? osc_lvl_reg : ext_lvl_reg;
        tick      = src_level && !src_prev_reg;
      end
      default:  tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      src_prev_reg <= 1'b1;
    else if (!timer_on || count_wr)
      // a falling edge must be seen before the first counted rise
      src_prev_reg <= 1'b1;
    else
      src_prev_reg <= src_level;
  end

  always_comb
  begin
    case (gctl_reg[GC_SS_LO +: 2])
      2'h0:    gsel = gpin_lvl_reg;
      2'h1:    gsel = timer0_overflow;
      2'h2:    gsel = c1_lvl_reg;
      2'h3:    gsel = c2_lvl_reg;
      default: gsel = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      toggle_reg    <= 1'b0;
      gsel_prev_reg <= 1'b0;
    end
    else
    begin
      gsel_prev_reg <= gsel;
      if (!timer_on || !gctl_reg[GC_TGL])
        toggle_reg <= 1'b0;
      else if (gsel && !gsel_prev_reg)
        toggle_reg <= !toggle_reg;
    end
  end

  assign gate_in = gctl_reg[GC_TGL] ? toggle_reg : gsel;

  always_comb
  begin
    gval = (gate_in == gctl_reg[GC_POL]);
    if (gctl_reg[GC_SPM])
      gval = pulse_open_reg;
  end

  // single-pulse window opens while armed and the gate is at its active level
  // armed opens on active level
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pulse_open_reg <= 1'b0;
    else if (!gctl_reg[GC_SPM])
      pulse_open_reg <= 1'b0;
    else if (pulse_open_reg)
      pulse_open_reg <= (gate_in == gctl_reg[GC_POL]);
    else if (gctl_reg[GC_ARM] && (gate_in == gctl_reg[GC_POL]))
      pulse_open_reg <= 1'b1;
  end

  assign gate_ok = !gctl_reg[GC_GE] || gval;
  assign ps_done = (ps_reg == ((3'h1 << ps) - 3'h1));
  assign inc = timer_on && gate_ok && tick && ps_done &&
               (!sleep_mode || (tctl_reg[TC_SYNC_BYP] && cs == CS_EXT));
  assign roll = inc && (count_reg == COUNT_MAX);
  assign count_wr = wr && (paddr == ADDR_COUNT_LOW ||
                           paddr == ADDR_COUNT_HIGH);
  assign match = (ccpv_reg == count_reg);
  assign trig_clear = (ccp_mode_reg == CCP_AUTOCONV) && match &&
                      !cmp_prev_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ps_reg <= 3'h0;
    else if (count_wr || !timer_on)
      ps_reg <= 3'h0;
    else if (timer_on && gate_ok && tick)
      ps_reg <= ps_done ? 3'h0 : ps_reg + 3'h1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      count_reg <= 16'h0000;
    else if (count_wr)
    begin
      if (paddr == ADDR_COUNT_LOW)
        count_reg[7:0] <= pwdata[7:0];
      else
        count_reg[15:8] <= pwdata[7:0];
    end
    else if (trig_clear)
      count_reg <= 16'h0000;
    else if (inc)
      count_reg <= count_reg + 16'h0001;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cmp_prev_reg <= 1'b0;
    else
      cmp_prev_reg <= match;
  end
  assign compare_event = (ccp_mode_reg == CCP_COMPARE ||
                          ccp_mode_reg == CCP_AUTOCONV) &&
                         match && !cmp_prev_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ccpv_reg <= 16'h0000;
    else if (ccp_mode_reg == CCP_CAPTURE && capture_event)
      ccpv_reg <= count_reg;
    else if (wr && paddr == ADDR_CCP_LOW)
      ccpv_reg[7:0] <= pwdata[7:0];
    else if (wr && paddr == ADDR_CCP_HIGH)
      ccpv_reg[15:8] <= pwdata[7:0];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tctl_reg     <= TC_RESET;
      ccp_mode_reg <= CCP_OFF;
      ien_reg      <= 5'h00;
    end
    else if (wr)
    begin
      if (paddr == ADDR_TIMER_CONTROL)
        tctl_reg <= pwdata[7:0] & TC_WMASK;
      if (paddr == ADDR_CCP_MODE)
        ccp_mode_reg <= pwdata[1:0];
      if (paddr == ADDR_IRQ_ENABLE)
        ien_reg <= pwdata[4:0];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gctl_reg <= GC_RESET;
    else
    begin
      if (wr && paddr == ADDR_GATE_CONTROL)
        gctl_reg <= pwdata[7:0] & ~(8'h01 << GC_VAL);
      if (pulse_open_reg && !(gate_in == gctl_reg[GC_POL]))
        gctl_reg[GC_ARM] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gval_prev_reg <= 1'b0;
    else
      gval_prev_reg <= gval;
  end

  // flags are write-one-to-clear; a hardware set in the same cycle wins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      flags_reg <= 3'h0;
    else
    begin
      if (wr && paddr == ADDR_FLAGS)
        flags_reg <= flags_reg & ~pwdata[2:0];
      if (roll)
        flags_reg[FL_ROLL] <= 1'b1;
      if (gval_prev_reg && !gval)
        flags_reg[FL_GATE] <= 1'b1;
      if (compare_event || (ccp_mode_reg == CCP_CAPTURE && capture_event))
        flags_reg[FL_CCP] <= 1'b1;
    end
  end

  assign irq = ien_reg[IE_GLOBAL] && ien_reg[IE_PERIPH] &&
               ((flags_reg[FL_ROLL] && ien_reg[FL_ROLL] && timer_on) ||
                (flags_reg[FL_GATE] && ien_reg[FL_GATE]));
  assign wake = sleep_mode && ien_reg[IE_PERIPH] && timer_on &&
                flags_reg[FL_ROLL] && ien_reg[FL_ROLL];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ADDR_TIMER_CONTROL: prdata <= {24'h0, tctl_reg};
        ADDR_GATE_CONTROL:
          prdata <= {24'h0, gctl_reg[7:3], gval, gctl_reg[1:0]};
        ADDR_COUNT_LOW:     prdata <= {24'h0, count_reg[7:0]};
        ADDR_COUNT_HIGH:    prdata <= {24'h0, count_reg[15:8]};
        ADDR_CCP_LOW:       prdata <= {24'h0, ccpv_reg[7:0]};
        ADDR_CCP_HIGH:      prdata <= {24'h0, ccpv_reg[15:8]};
        ADDR_CCP_MODE:      prdata <= {30'h0, ccp_mode_reg};
        ADDR_FLAGS:         prdata <= {29'h0, flags_reg};
        ADDR_IRQ_ENABLE:    prdata <= {27'h0, ien_reg};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : gated_sixteen_bit_timer

// >>> gtimer_asserts.sv
`timescale 1ns/1ps
module gtimer_asserts
  import gtimer_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        compare_event,
  input wire logic        irq
);
  logic rd_acc;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  assign rd_acc = psel && penable && !pwrite;

  a_access_ready: assert property (
    psel && penable |-> pready && !pslverr)
    else $error("access not completed at once");
  a_ctl_spare_zero: assert property (
    rd_acc && paddr == ADDR_TIMER_CONTROL |-> !prdata[1])
    else $error("control spare bit read high");
  a_byte_wide: assert property (
    rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_hole_zero: assert property (
    rd_acc && paddr > ADDR_IRQ_ENABLE |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_cmp_one_pulse: assert property (
    compare_event |=> !compare_event)
    else $error("compare event longer than one cycle");
  a_rd_data_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_irq_quiet_rst: assert property (
    $fell(rst) |-> !irq ##1 !irq)
    else $error("irq after reset");
  a_cmp_quiet_rst: assert property (
    $fell(rst) |-> !compare_event[*2])
    else $error("compare event after reset");
endmodule : gtimer_asserts

// >>> gtimer_pkg.sv
package gtimer_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GATE_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'h08;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h0C;
  localparam logic [7:0] ADDR_CCP_LOW       = 8'h10;
  localparam logic [7:0] ADDR_CCP_HIGH      = 8'h14;
  localparam logic [7:0] ADDR_CCP_MODE      = 8'h18;
  localparam logic [7:0] ADDR_FLAGS         = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h20;

  // timer_control fields
  localparam int TC_ON        = 0;
  localparam int TC_SYNC_BYP  = 2;
  localparam int TC_OSC_EN    = 3;
  localparam int TC_PS_LO     = 4;
  localparam int TC_CS_LO     = 6;
  localparam logic [7:0] TC_WMASK = 8'hFD;
  localparam logic [7:0] TC_RESET = 8'h00;

  // gate_control fields
  localparam int GC_SS_LO  = 0;
  localparam int GC_VAL    = 2;
  localparam int GC_ARM    = 3;
  localparam int GC_SPM    = 4;
  localparam int GC_TGL    = 5;
  localparam int GC_POL    = 6;
  localparam int GC_GE     = 7;
  localparam logic [7:0] GC_RESET = 8'h00;

  // flags / irq enable fields
  localparam int FL_ROLL  = 0;
  localparam int FL_GATE  = 1;
  localparam int FL_CCP   = 2;
  localparam int IE_PERIPH = 3;
  localparam int IE_GLOBAL = 4;

  // capture/compare mode codes
  localparam logic [1:0] CCP_OFF      = 2'h0;
  localparam logic [1:0] CCP_CAPTURE  = 2'h1;
  localparam logic [1:0] CCP_COMPARE  = 2'h2;
  localparam logic [1:0] CCP_AUTOCONV = 2'h3;

  localparam logic [1:0] CS_FOSC4 = 2'h0;
  localparam logic [1:0] CS_FOSC  = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;

  localparam logic [1:0] FOSC4_DIV_LAST = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : gtimer_pkg

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  import gtimer_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, gate_req, cap_req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, ext_pin, gate_pin, cmp1, cmp2;
  logic        cap_ev, cmp_ev, irq, wake, slp, sosc_out;
  logic [15:0] v, w;
  logic [1:0]  cs, ps;
  int          err_total, n_checks, cyc, n_cmp, e;

  gated_sixteen_bit_timer gated_sixteen_bit_timer_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
    .secondary_osc_input(1'b0), .secondary_osc_output(sosc_out),
    .gate_pin(gate_pin), .timer0_overflow(!gate_req),
    .comparator_one_output(cmp1), .comparator_two_output(cmp2),
    .capture_event(cap_ev), .sleep_mode(slp), .compare_event(cmp_ev),
    .irq(irq), .wake(wake));
  gate_side_model gate_side_model_inst (
    .mclk(mclk), .gate_req(gate_req), .cap_req(cap_req),
    .gate_pin(gate_pin), .comparator_one_output(cmp1),
    .comparator_two_output(cmp2), .capture_event(cap_ev),
    .external_count_pin(ext_pin));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cmp_ev === 1'b1)
      n_cmp <= n_cmp + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] g);
    n_checks++;
    if (g !== x)
      $display("wrong value %s exp %h got %h", nm, x, g);
    if (g !== x)
      err_total++;
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input logic [15:0] g);
    n_checks++;
    if ((^g === 1'bx) || int'(g) < lo || int'(g) > hi)
    begin
      err_total++;
      $display("wrong value %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  // request held until pready is sampled; an idle edge follows the release
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic rd16(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    v[7:0] = rd[7:0];
    apb(1'b0, a + 8'h04, 32'h0);
    v[15:8] = rd[7:0];
  endtask : rd16

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {24'h0, d[7:0]});
    apb(1'b1, a + 8'h04, {24'h0, d[15:8]});
  endtask : wr16

  // a run lasts 163 edges between the on and off writes
  function automatic int exp_cnt(input logic [1:0] c, input logic [1:0] p);
    int b;
    b = (c == CS_FOSC4) ? 40 : (c == CS_FOSC) ? 163 : (c == CS_EXT) ? 20 : 0;
    return b >> p;
  endfunction : exp_cnt

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gate_req = 1'b0;
    cap_req = 1'b0;
    slp = 1'b0;
    e = $urandom(32'hF92E252B);
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
    chk("tctl", {8'h00, TC_RESET}, rd[15:0]);
    apb(1'b1, 8'h24, 32'hFF);
    apb(1'b0, 8'h24, 32'h0);
    chk("hole", 16'h0000, rd[15:0]);
    repeat (4)
    begin
      w = 16'($urandom) & 16'h00FE;
      apb(1'b1, ADDR_TIMER_CONTROL, {16'h0, w});
      apb(1'b0, ADDR_TIMER_CONTROL, 32'h0);
      chk("tctl", w & {8'h00, TC_WMASK}, rd[15:0]);
      chk("osc", {15'h0, w[TC_OSC_EN]}, {15'h0, sosc_out});
    end
    for (int i = 0; i < 7; i++)
    begin
      cs = (i < 4) ? 2'(i) : CS_FOSC;
      ps = (i < 4) ? 2'h0 : 2'(i - 3);
      wr16(ADDR_COUNT_LOW, 16'h0000);
      apb(1'b1, ADDR_TIMER_CONTROL, {24'h0, cs, ps, 4'h1});
      repeat (160) @(posedge mclk);
      apb(1'b1, ADDR_TIMER_CONTROL, {24'h0, cs, ps, 4'h0});
      rd16(ADDR_COUNT_LOW);
      chk_rng("count", exp_cnt(cs, ps) - 2, exp_cnt(cs, ps) + 2, v);
    end
    $display("clock and prescale done");
    apb(1'b1, ADDR_FLAGS, 32'h7);
    wr16(ADDR_COUNT_LOW, 16'hFFF0);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h19);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
    repeat (30) @(posedge mclk);
    chk("irq", 16'h0001, {15'h0, irq});
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h09);
    chk("irq", 16'h0000, {15'h0, irq});
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h19);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
    // rollover irq also needs the timer on
    chk("irq", 16'h0000, {15'h0, irq});
    rd16(ADDR_COUNT_LOW);
    chk_rng("wrap", 21, 25, v);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("roll", 16'h0001, rd[15:0] & 16'h0001);
    slp <= 1'b1;
    apb(1'b1, ADDR_FLAGS, 32'h7);
    wr16(ADDR_COUNT_LOW, 16'hFFFC);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h09);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
    repeat (40) @(posedge mclk);
    rd16(ADDR_COUNT_LOW);
    chk("asleep", 16'hFFFC, v);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h85);
    repeat (60) @(posedge mclk);
    chk("wake", 16'h0001, {15'h0, wake});
    chk("irq", 16'h0000, {15'h0, irq});
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h0);
    slp <= 1'b0;
    $display("rollover done");
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, ADDR_FLAGS, 32'h7);
      apb(1'b1, ADDR_GATE_CONTROL, 32'h40 + 32'(s));
      gate_req <= 1'b1;
      repeat (8) @(posedge mclk);
      apb(1'b0, ADDR_GATE_CONTROL, 32'h0);
      chk("gval", (s == 1 || s == 3) ? 16'h0 : 16'h4, rd[15:0] & 16'h4);
      gate_req <= 1'b0;
      repeat (8) @(posedge mclk);
      apb(1'b0, ADDR_FLAGS, 32'h0);
      chk("gflag", 16'h0002, rd[15:0] & 16'h0002);
    end
    wr16(ADDR_COUNT_LOW, 16'h0000);
    apb(1'b1, ADDR_GATE_CONTROL, 32'hD0);
    apb(1'b1, ADDR_GATE_CONTROL, 32'hD8);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
    // the second pulse must not add to the first
    for (int p = 0; p < 2; p++)
    begin
      repeat (10) @(posedge mclk);
      gate_req <= 1'b1;
      repeat (20) @(posedge mclk);
      gate_req <= 1'b0;
      repeat (10) @(posedge mclk);
      rd16(ADDR_COUNT_LOW);
      chk_rng("pulse", 18, 22, v);
    end
    apb(1'b0, ADDR_GATE_CONTROL, 32'h0);
    chk("arm", 16'h0000, rd[15:0] & 16'h0008);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
    apb(1'b1, ADDR_GATE_CONTROL, 32'h0);
    // toggle plus single pulse: one full gate period is counted
    wr16(ADDR_COUNT_LOW, 16'h0000);
    apb(1'b1, ADDR_GATE_CONTROL, 32'hF0);
    apb(1'b1, ADDR_GATE_CONTROL, 32'hF8);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
    repeat (2)
    begin
      gate_req <= 1'b1;
      repeat (10) @(posedge mclk);
      gate_req <= 1'b0;
      repeat (10) @(posedge mclk);
    end
    repeat (10) @(posedge mclk);
    rd16(ADDR_COUNT_LOW);
    chk_rng("cycle", 18, 22, v);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
    apb(1'b1, ADDR_GATE_CONTROL, 32'h0);
    $display("single pulse done");
    w = 16'($urandom);
    wr16(ADDR_COUNT_LOW, w);
    apb(1'b1, ADDR_CCP_MODE, {30'h0, CCP_CAPTURE});
    cap_req <= 1'b1;
    @(posedge mclk);
    cap_req <= 1'b0;
    repeat (3) @(posedge mclk);
    rd16(ADDR_CCP_LOW);
    chk("capture", w, v);
    apb(1'b1, ADDR_FLAGS, 32'h7);
    wr16(ADDR_COUNT_LOW, 16'h0000);
    wr16(ADDR_CCP_LOW, 16'h0028);
    apb(1'b1, ADDR_CCP_MODE, {30'h0, CCP_AUTOCONV});
    e = n_cmp;
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
    repeat (200) @(posedge mclk);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
    chk_rng("matches", 3, 5, 16'(n_cmp - e));
    rd16(ADDR_COUNT_LOW);
    chk_rng("period", 0, 40, v);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("noroll", 16'h0000, rd[15:0] & 16'h0001);
    // the high byte write lands in the very cycle of the trigger clear
    wr16(ADDR_COUNT_LOW, 16'h0000);
    wr16(ADDR_CCP_LOW, 16'h0002);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h41);
    apb(1'b1, ADDR_COUNT_HIGH, 32'h12);
    apb(1'b1, ADDR_TIMER_CONTROL, 32'h40);
    rd16(ADDR_COUNT_LOW);
    chk("wrwins", 16'h1205, v);
    $display("capture compare done");
    test_done();
  end
endmodule : tb

bind gated_sixteen_bit_timer gtimer_asserts gtimer_asserts_inst (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .compare_event(compare_event), .irq(irq));
